//--- shared/ccp_pkg.sv
// Constants, types and register map of the dual capture channel block.
package ccp_pkg;

    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CH_COUNT = 2;

    // Register indices
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_CAP0_LO = 4'h2;
    localparam logic [3:0] OFS_CAP0_HI = 4'h3;
    localparam logic [3:0] OFS_CAP1_LO = 4'h4;
    localparam logic [3:0] OFS_CAP1_HI = 4'h5;
    localparam logic [3:0] OFS_TIMER3_CTRL = 4'h6;
    localparam logic [3:0] OFS_FLAGS = 4'h7;
    localparam logic [3:0] OFS_ENABLES = 4'h8;
    localparam logic [3:0] OFS_CONFIG = 4'h9;

    // Field positions
    localparam int SEL_CH0_POS = 3;
    localparam int SEL_CH1_POS = 6;
    localparam int ROUTE_POS = 0;
    localparam int CTRL_W = 6;

    // Mode field encodings
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
    localparam logic [1:0] CLASS_CAPTURE = 2'h1;
    localparam logic [1:0] CLASS_PWM = 2'h3;

    // Prescaler last counts (count runs 0 .. last)
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

    // Reset values
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic SEL_RESET = 1'b0;
    localparam logic ROUTE_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [3:0] PRESCALE_RESET = 4'h0;

    typedef enum logic [1:0] {
        TB_FIRST = 2'b00,
        TB_SECOND = 2'b01,
        TB_THIRD = 2'b11
    } time_base_e;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
        logic [15:0] third;
    } time_bases_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

    typedef struct packed {
        logic first_reset;
        logic third_reset;
        logic conversion_start;
    } trigger_s;

endpackage

//--- hdl/dual_capture_timer_select.sv
// Two capture/compare channels with time base selection and edge prescaler.
`timescale 1ns/1ps

module dual_capture_timer_select (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire ccp_pkg::reg_req_s i_reg,
    output logic [7:0] o_rdata,
    // Time bases
    input wire ccp_pkg::time_bases_s i_time_bases,
    input wire logic i_first_timer_async,
    // Pin levels
    input wire logic i_first_channel_pin,
    input wire logic i_port_c_alt_pin,
    input wire logic i_port_b_alt_pin,
    // Status and triggers
    output logic [1:0] o_capture_strobe,
    output logic [1:0] o_channel_event_flag,
    output logic [1:0] o_channel_event_enable,
    output ccp_pkg::time_base_e o_first_channel_time_base,
    output ccp_pkg::time_base_e o_second_channel_time_base,
    output ccp_pkg::trigger_s o_trigger
);

    // Software visible state
    logic [5:0] channel_control [2];
    logic [15:0] capture_value_pair [2];
    logic [1:0] timer_select;
    logic second_channel_pin_route;
    logic [1:0] channel_event_flag;
    logic [1:0] channel_event_enable;

    // Per channel working signals
    logic [1:0] raw_pin;
    logic [1:0] event_fire;
    logic [1:0] trig_first;
    logic [1:0] trig_third;
    logic [1:0] trig_any;
    ccp_pkg::time_base_e time_base [2];

    // Address decode
    wire wr_ctrl0 = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CTRL0);
    wire wr_ctrl1 = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CTRL1);
    wire wr_cap0_lo = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CAP0_LO);
    wire wr_cap0_hi = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CAP0_HI);
    wire wr_cap1_lo = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CAP1_LO);
    wire wr_cap1_hi = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CAP1_HI);
    wire wr_timer3 = i_reg.write && (i_reg.addr == ccp_pkg::OFS_TIMER3_CTRL);
    wire wr_flags = i_reg.write && (i_reg.addr == ccp_pkg::OFS_FLAGS);
    wire wr_enables = i_reg.write && (i_reg.addr == ccp_pkg::OFS_ENABLES);
    wire wr_config = i_reg.write && (i_reg.addr == ccp_pkg::OFS_CONFIG);

    wire [1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
    wire [1:0] wr_cap_lo = {wr_cap1_lo, wr_cap0_lo};
    wire [1:0] wr_cap_hi = {wr_cap1_hi, wr_cap0_hi};

    // Second channel pin routing; a route change can look like an edge
    assign raw_pin[0] = i_first_channel_pin;
    assign raw_pin[1] = second_channel_pin_route ? i_port_c_alt_pin
                                                 : i_port_b_alt_pin;

    // Loose configuration bits
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_select <= {ccp_pkg::SEL_RESET, ccp_pkg::SEL_RESET};
            second_channel_pin_route <= ccp_pkg::ROUTE_RESET;
            channel_event_enable <= {ccp_pkg::ENABLE_RESET, ccp_pkg::ENABLE_RESET};
        end else begin
            if (wr_timer3) begin
                timer_select[0] <= i_reg.wdata[ccp_pkg::SEL_CH0_POS];
                timer_select[1] <= i_reg.wdata[ccp_pkg::SEL_CH1_POS];
            end
            if (wr_config) begin
                second_channel_pin_route <= i_reg.wdata[ccp_pkg::ROUTE_POS];
            end
            if (wr_enables) begin
                channel_event_enable <= i_reg.wdata[1:0];
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < ccp_pkg::CH_COUNT; ch++) begin : g_channel
            logic [2:0] pin_sync;
            logic pin_level;
            logic [3:0] prescale;
            logic match_q;

            wire [3:0] mode = channel_control[ch][3:0];
            wire is_capture = (mode[3:2] == ccp_pkg::CLASS_CAPTURE);
            wire is_pwm = (mode[3:2] == ccp_pkg::CLASS_PWM);

            // Capture/compare picks first or third timer, PWM the second
            assign time_base[ch] = is_pwm ? ccp_pkg::TB_SECOND
                                 : (timer_select[ch] ? ccp_pkg::TB_THIRD
                                                     : ccp_pkg::TB_FIRST);

            wire [15:0] base_count = (time_base[ch] == ccp_pkg::TB_THIRD)
                                   ? i_time_bases.third
                                   : (time_base[ch] == ccp_pkg::TB_SECOND)
                                   ? i_time_bases.second
                                   : i_time_bases.first;

            // Asynchronous first timer gives no trustworthy count
            wire base_ok = !((time_base[ch] == ccp_pkg::TB_FIRST)
                             && i_first_timer_async);

            // Edges from the filtered pin level, in or out alike
            wire agree = (pin_sync[1] == pin_sync[2]);
            wire next_pin_level = agree ? pin_sync[2] : pin_level;
            wire rise = next_pin_level && !pin_level;
            wire fall = !next_pin_level && pin_level;

            wire is_rise4 = (mode == ccp_pkg::MODE_CAP_RISE4);
            wire is_rise16 = (mode == ccp_pkg::MODE_CAP_RISE16);
            wire [3:0] prescale_last = is_rise16 ? ccp_pkg::PRESCALE_16_LAST
                                                 : ccp_pkg::PRESCALE_4_LAST;
            // A count left high by a setting change wraps at the new limit
            wire prescale_done = (prescale >= prescale_last);
            wire counting = is_rise4 || is_rise16;

            wire [3:0] next_prescale = !is_capture ? ccp_pkg::PRESCALE_RESET
                                     : (counting && rise)
                                       ? (prescale_done ? ccp_pkg::PRESCALE_RESET
                                                        : prescale + 4'h1)
                                     : prescale;

            wire capture_event = (mode == ccp_pkg::MODE_CAP_FALL && fall)
                               || (mode == ccp_pkg::MODE_CAP_RISE && rise)
                               || (counting && rise && prescale_done);

            // Compare special event trigger on the first cycle of a match
            wire match = (mode == ccp_pkg::MODE_CMP_TRIGGER) && base_ok
                       && (capture_value_pair[ch] == base_count);
            wire compare_event = match && !match_q;

            assign event_fire[ch] = (capture_event && base_ok) || compare_event;
            assign trig_first[ch] = compare_event
                                  && (time_base[ch] == ccp_pkg::TB_FIRST);
            assign trig_third[ch] = compare_event
                                  && (time_base[ch] == ccp_pkg::TB_THIRD);
            assign trig_any[ch] = compare_event;

            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    pin_sync <= ccp_pkg::SYNC_RESET;
                    pin_level <= 1'b0;
                    prescale <= ccp_pkg::PRESCALE_RESET;
                    match_q <= 1'b0;
                end else begin
                    pin_sync <= {pin_sync[1:0], raw_pin[ch]};
                    pin_level <= next_pin_level;
                    prescale <= next_prescale;
                    match_q <= match;
                end
            end

            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    channel_control[ch] <= ccp_pkg::CTRL_RESET;
                end else if (wr_ctrl[ch]) begin
                    channel_control[ch] <= i_reg.wdata[5:0];
                end
            end

            // Hardware capture beats a software write in the same cycle
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    capture_value_pair[ch] <= ccp_pkg::CAP_RESET;
                end else if (capture_event && base_ok) begin
                    capture_value_pair[ch] <= base_count;
                end else if (wr_cap_lo[ch]) begin
                    capture_value_pair[ch][7:0] <= i_reg.wdata;
                end else if (wr_cap_hi[ch]) begin
                    capture_value_pair[ch][15:8] <= i_reg.wdata;
                end
            end

            // Set wins over a clear in the same cycle
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    channel_event_flag[ch] <= ccp_pkg::FLAG_RESET;
                end else if (event_fire[ch]) begin
                    channel_event_flag[ch] <= 1'b1;
                end else if (wr_flags && i_reg.wdata[ch]) begin
                    channel_event_flag[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // Shared timer resets simply combine; simultaneous ones do not fight
    wire next_first_reset = |trig_first;
    wire next_third_reset = |trig_third;
    wire next_conversion = trig_any[1];

    // Read selection
    logic [7:0] read_value;
    always_comb begin
        read_value = 8'h00;
        unique case (i_reg.addr)
            ccp_pkg::OFS_CTRL0: read_value = {2'h0, channel_control[0]};
            ccp_pkg::OFS_CTRL1: read_value = {2'h0, channel_control[1]};
            ccp_pkg::OFS_CAP0_LO: read_value = capture_value_pair[0][7:0];
            ccp_pkg::OFS_CAP0_HI: read_value = capture_value_pair[0][15:8];
            ccp_pkg::OFS_CAP1_LO: read_value = capture_value_pair[1][7:0];
            ccp_pkg::OFS_CAP1_HI: read_value = capture_value_pair[1][15:8];
            ccp_pkg::OFS_TIMER3_CTRL: begin
                read_value[ccp_pkg::SEL_CH0_POS] = timer_select[0];
                read_value[ccp_pkg::SEL_CH1_POS] = timer_select[1];
            end
            ccp_pkg::OFS_FLAGS: read_value = {6'h00, channel_event_flag};
            ccp_pkg::OFS_ENABLES: read_value = {6'h00, channel_event_enable};
            ccp_pkg::OFS_CONFIG: read_value = {7'h00, second_channel_pin_route};
            default: read_value = 8'h00;
        endcase
    end

    // Registered outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
            o_capture_strobe <= 2'h0;
            o_trigger <= '0;
        end else begin
            o_rdata <= i_reg.read ? read_value : 8'h00;
            o_capture_strobe <= event_fire & ~trig_any;
            o_trigger.first_reset <= next_first_reset;
            o_trigger.third_reset <= next_third_reset;
            o_trigger.conversion_start <= next_conversion;
        end
    end

    // PWM on both channels always lands on the second timer
    assign o_first_channel_time_base = time_base[0];
    assign o_second_channel_time_base = time_base[1];
    assign o_channel_event_flag = channel_event_flag;
    assign o_channel_event_enable = channel_event_enable;

endmodule

//--- tb/pin_source.sv
// Behavioural source of the three capture pin levels.
`timescale 1ns/1ps
module pin_source (
    // Clock
    input wire logic i_clk,
    // Pin levels
    output logic o_first_channel_pin,
    output logic o_port_c_alt_pin,
    output logic o_port_b_alt_pin
);
    // Pins are driven from outside only, as inputs of the block
    initial begin
        o_first_channel_pin = 1'b0;
        o_port_c_alt_pin = 1'b0;
        o_port_b_alt_pin = 1'b0;
    end

    // Each level is held well past the synchroniser so every edge is seen
    task automatic set_pin(input int sel, input logic v);
        @(posedge i_clk);
        case (sel)
            0: o_first_channel_pin <= v;
            1: o_port_c_alt_pin <= v;
            default: o_port_b_alt_pin <= v;
        endcase
        repeat (6) @(posedge i_clk);
        #1;
    endtask

    task automatic pulses(input int sel, input int n);
        repeat (n) begin
            set_pin(sel, 1'b1);
            set_pin(sel, 1'b0);
        end
    endtask
endmodule

//--- tb/dual_capture_timer_select_assertions.sv
// Checker watching the ports of the dual capture block.
`timescale 1ns/1ps
module dual_capture_timer_select_assertions (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Watched ports
    input wire ccp_pkg::reg_req_s i_reg,
    input wire logic [7:0] o_rdata,
    input wire ccp_pkg::time_bases_s i_time_bases,
    input wire logic i_first_timer_async,
    input wire logic i_first_channel_pin,
    input wire logic i_port_c_alt_pin,
    input wire logic i_port_b_alt_pin,
    input wire logic [1:0] o_capture_strobe,
    input wire logic [1:0] o_channel_event_flag,
    input wire logic [1:0] o_channel_event_enable,
    input wire ccp_pkg::time_base_e o_first_channel_time_base,
    input wire ccp_pkg::time_base_e o_second_channel_time_base,
    input wire ccp_pkg::trigger_s o_trigger
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Mirror of the first control register
    logic [5:0] ctrl0;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl0 <= ccp_pkg::CTRL_RESET;
        end else if (i_reg.write && i_reg.addr == ccp_pkg::OFS_CTRL0) begin
            ctrl0 <= i_reg.wdata[5:0];
        end
    end

    sequence s_flag0_kept;
        o_channel_event_flag[0] && !(i_reg.write && i_reg.addr == ccp_pkg::OFS_FLAGS
            && i_reg.wdata[0]);
    endsequence
    sequence s_async_first1;
        (i_first_timer_async && o_second_channel_time_base == ccp_pkg::TB_FIRST)[*6];
    endsequence

    property p_strobe_pulse;
        o_capture_strobe[0] |=> !o_capture_strobe[0];
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
    property p_strobe_flag;
        o_capture_strobe[1] |-> o_channel_event_flag[1];
    endproperty
    a_strobe_flag: assert property (p_strobe_flag) else $error("capture without flag");
    property p_flag_sticky;
        s_flag0_kept |=> o_channel_event_flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by hardware");
    property p_async_block;
        s_async_first1 |-> !o_capture_strobe[1];
    endproperty
    a_async_block: assert property (p_async_block) else $error("capture from async timer");
    property p_select;
        i_reg.write && i_reg.addr == ccp_pkg::OFS_TIMER3_CTRL |=>
            o_first_channel_time_base == ccp_pkg::TB_SECOND ||
            o_first_channel_time_base == ($past(i_reg.wdata[ccp_pkg::SEL_CH0_POS]) ?
                ccp_pkg::TB_THIRD : ccp_pkg::TB_FIRST);
    endproperty
    a_select: assert property (p_select) else $error("time base ignores select bit");
    property p_pwm_second;
        (ctrl0[3:2] == 2'b11) == (o_first_channel_time_base == ccp_pkg::TB_SECOND);
    endproperty
    a_pwm_second: assert property (p_pwm_second) else $error("wrong timer class");
    property p_conv;
        o_trigger.conversion_start |-> (o_second_channel_time_base == ccp_pkg::TB_THIRD ?
            o_trigger.third_reset : o_trigger.first_reset);
    endproperty
    a_conv: assert property (p_conv) else $error("conversion without timer reset");
    property p_first_reset;
        o_trigger.first_reset |-> o_first_channel_time_base == ccp_pkg::TB_FIRST ||
            o_second_channel_time_base == ccp_pkg::TB_FIRST;
    endproperty
    a_first_reset: assert property (p_first_reset) else $error("reset of unused timer");
    property p_ctrl_readback;
        i_reg.read && i_reg.addr == ccp_pkg::OFS_CTRL0 |=> o_rdata == {2'h0, ctrl0};
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("mode readback wrong");
endmodule

//--- tb/test_dual_capture_timer_select.sv
// Self-checking bench of the dual capture block.
`timescale 1ns/1ps
module test_dual_capture_timer_select;
    logic i_clk;
    logic i_reset_n;
    ccp_pkg::reg_req_s i_reg;
    logic [7:0] o_rdata;
    ccp_pkg::time_bases_s i_time_bases;
    logic i_first_timer_async;
    logic pin0;
    logic pin_c;
    logic pin_b;
    logic [1:0] strobe;
    logic [1:0] flag;
    logic [1:0] enable;
    ccp_pkg::time_base_e tb0;
    ccp_pkg::time_base_e tb1;
    ccp_pkg::trigger_s trig;
    int err_total;
    int compares;
    int cycles;
    logic [7:0] lo;
    logic [7:0] hi;

    dual_capture_timer_select DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg(i_reg),
        .o_rdata(o_rdata), .i_time_bases(i_time_bases), .i_first_timer_async(i_first_timer_async),
        .i_first_channel_pin(pin0), .i_port_c_alt_pin(pin_c), .i_port_b_alt_pin(pin_b),
        .o_capture_strobe(strobe), .o_channel_event_flag(flag), .o_channel_event_enable(enable),
        .o_first_channel_time_base(tb0), .o_second_channel_time_base(tb1), .o_trigger(trig));
    pin_source pins (.i_clk(i_clk), .o_first_channel_pin(pin0), .o_port_c_alt_pin(pin_c),
        .o_port_b_alt_pin(pin_b));

    always #12.5 i_clk = ~i_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge i_clk);
        i_reg.write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_reg <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge i_clk);
        i_reg.read <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic cap_check(input logic [3:0] a, input logic [15:0] exp);
        rd(a, lo);
        rd(a + 4'h1, hi);
        check({hi, lo}, exp);
    endtask
    // Bounded wait for a compare trigger pulse
    task automatic wait_trig(input logic first);
        for (int k = 0; k < 20; k++) begin
            @(posedge i_clk);
            #1;
            if ((first ? trig.first_reset : trig.third_reset) === 1'b1) break;
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d of %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        i_reg = '0;
        i_time_bases = '0;
        i_first_timer_async = 1'b0;
        err_total = 0;
        compares = 0;
        cycles = 0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        check(flag, 2'b00);
        check(tb0, ccp_pkg::TB_FIRST);
        rd(ccp_pkg::OFS_CONFIG, lo);
        check(lo, 8'h01);
        rd(4'hf, lo);
        check(lo, 8'h00);
        wr(ccp_pkg::OFS_ENABLES, 8'h03);
        check(enable, 2'b11);
        wr(ccp_pkg::OFS_TIMER3_CTRL, 8'h08);
        check(tb0, ccp_pkg::TB_THIRD);
        for (int m = 4; m < 8; m++) begin
            wr(ccp_pkg::OFS_CTRL0, 8'h00);
            @(posedge i_clk) i_time_bases.third <= 16'hc0d0 + 16'(m);
            wr(ccp_pkg::OFS_CTRL0, 8'(m));
            wr(ccp_pkg::OFS_FLAGS, 8'h03);
            pins.pulses(0, m == 7 ? 15 : (m == 6 ? 3 : 0));
            check(flag[0], 1'b0);
            pins.set_pin(0, 1'b1);
            check(flag[0], m != 4);
            pins.set_pin(0, 1'b0);
            check(flag[0], 1'b1);
            cap_check(ccp_pkg::OFS_CAP0_LO, 16'hc0d0 + 16'(m));
        end
        wr(ccp_pkg::OFS_CTRL0, 8'h0c);
        check(tb0, ccp_pkg::TB_SECOND);
        // Direct prescaler switch keeps the partial count
        wr(ccp_pkg::OFS_CTRL0, 8'h06);
        wr(ccp_pkg::OFS_FLAGS, 8'h03);
        pins.pulses(0, 2);
        wr(ccp_pkg::OFS_CTRL0, 8'h07);
        pins.pulses(0, 13);
        check(flag[0], 1'b0);
        pins.pulses(0, 1);
        check(flag[0], 1'b1);
        // Turning the channel off clears the count
        wr(ccp_pkg::OFS_CTRL0, 8'h06);
        pins.pulses(0, 3);
        wr(ccp_pkg::OFS_CTRL0, 8'h00);
        wr(ccp_pkg::OFS_CTRL0, 8'h06);
        wr(ccp_pkg::OFS_FLAGS, 8'h03);
        pins.pulses(0, 3);
        check(flag[0], 1'b0);
        pins.pulses(0, 1);
        check(flag[0], 1'b1);
        // Second channel on the first timer, both channels running
        @(posedge i_clk) i_time_bases.first <= 16'h2222;
        wr(ccp_pkg::OFS_CTRL1, 8'h05);
        wr(ccp_pkg::OFS_CTRL0, 8'h05);
        wr(ccp_pkg::OFS_FLAGS, 8'h03);
        pins.pulses(2, 1);
        check(flag[1], 1'b0);
        pins.pulses(1, 1);
        check(flag, 2'b10);
        @(posedge i_clk) i_time_bases.first <= 16'h3333;
        pins.pulses(1, 1);
        cap_check(ccp_pkg::OFS_CAP1_LO, 16'h3333);
        wr(ccp_pkg::OFS_CONFIG, 8'h00);
        wr(ccp_pkg::OFS_FLAGS, 8'h03);
        pins.pulses(1, 1);
        check(flag[1], 1'b0);
        pins.pulses(2, 1);
        check(flag[1], 1'b1);
        @(posedge i_clk) i_first_timer_async <= 1'b1;
        wr(ccp_pkg::OFS_FLAGS, 8'h03);
        pins.pulses(2, 1);
        check(flag[1], 1'b0);
        @(posedge i_clk) i_first_timer_async <= 1'b0;
        // Compare triggers on the third and first timers
        wr(ccp_pkg::OFS_TIMER3_CTRL, 8'h48);
        @(posedge i_clk) i_time_bases.third <= 16'h0777;
        wr(ccp_pkg::OFS_CAP1_LO, 8'h77);
        wr(ccp_pkg::OFS_CAP1_HI, 8'h07);
        wr(ccp_pkg::OFS_CTRL1, 8'h0b);
        wait_trig(1'b0);
        check(trig.conversion_start, 1'b1);
        wr(ccp_pkg::OFS_TIMER3_CTRL, 8'h40);
        @(posedge i_clk) i_time_bases.first <= 16'h0abc;
        wr(ccp_pkg::OFS_CAP0_LO, 8'hbc);
        wr(ccp_pkg::OFS_CAP0_HI, 8'h0a);
        wr(ccp_pkg::OFS_CTRL0, 8'h0b);
        wait_trig(1'b1);
        check(trig.first_reset, 1'b1);
        check(trig.conversion_start, 1'b0);
        conclude();
    end
endmodule

bind dual_capture_timer_select dual_capture_timer_select_assertions chk (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_reg(i_reg), .o_rdata(o_rdata), .i_time_bases(i_time_bases),
    .i_first_timer_async(i_first_timer_async), .i_first_channel_pin(i_first_channel_pin),
    .i_port_c_alt_pin(i_port_c_alt_pin), .i_port_b_alt_pin(i_port_b_alt_pin),
    .o_capture_strobe(o_capture_strobe), .o_channel_event_flag(o_channel_event_flag),
    .o_channel_event_enable(o_channel_event_enable),
    .o_first_channel_time_base(o_first_channel_time_base),
    .o_second_channel_time_base(o_second_channel_time_base), .o_trigger(o_trigger));
